// *** design/ppfdm_cfg.svh ***
// Timing and field constants for the port power fault monitor.
`ifndef PPFDM_CFG_SVH
`define PPFDM_CFG_SVH
`define PPFDM_CLK_MHZ 250
`define PPFDM_T_ILIM_MS 16
`define PPFDM_T_OCP_OFF_US 50
`define PPFDM_T_OCP_ON_US 250
`define PPFDM_T_OVP_ON_US 250
`define PPFDM_T_UV_MS 16
`define PPFDM_T_PREBIAS_US 10
`define PPFDM_T_VCL_US 400
`define PPFDM_T_VCH_US 5
`define PPFDM_CYC_US(t) ((t) * `PPFDM_CLK_MHZ)
`define PPFDM_CYC_MS(t) ((t) * 1000 * `PPFDM_CLK_MHZ)
`define PPFDM_THIRD_FAULT 2'h3
`define PPFDM_FS_OCP 0
`define PPFDM_FS_OVP 1
`define PPFDM_FS_HOST 2
`define PPFDM_FS_VCONN 3
`endif

// *** design/ppfdm_pkg.sv ***
// Types shared by the port power fault monitor.
package ppfdm_pkg;
   typedef struct packed {
      logic usb_rail_undervolt;
      logic limit_exceeded;
      logic in_current_regulation;
      logic mode_change;
      logic bus_overcurrent;
      logic bus_overvoltage;
      logic bus_undervoltage;
      logic output_short_ground;
      logic host_error;
      logic cable_power_low_overcurrent;
      logic cable_power_overcurrent;
      logic cable_power_input_undervolt;
      logic protection_summary;
   } ppfdm_flags_t;
endpackage

// *** design/ppfdm_monitor.sv ***
// Fault debounce, flag, action and alert logic for a Type-C source port.
// Overview of operation
// - Limit mode off: 16ms over limit flags class A; on: regulation, no fault.
// - Overvoltage ignored when off or soft-starting; also transitions, mode off.
// - Mode off: undervoltage 16ms sets flag and summary, class C, with blanking.
// - Mode on: undervoltage only outside regulation, same debounce and class.
// - Output short to ground flagged at once, class A; comparator by mode.
// - Default-voltage command above safe zero gives host error after 10us.
// - Cable low overcurrent 400us is class B; reported on third fault.
// - Cable high overcurrent 5us is class B; reported on third fault.
// - Cable enable clear and fast undervolt: flag at once, class B.
// - Vendor alert needs summary mask; fault status needs its own mask.
// - Class A alerts, kills converter, opens switches, discharges, resets.
// - After class A converter stays off until host re-enables it.
// - Class C only alerts; class B opens cable switch, alerts on third overcurrent or at once on fast undervolt.
`timescale 1ns/1ps
`include "ppfdm_cfg.svh"
module ppfdm_monitor #(
   parameter int ILIM_CYC = `PPFDM_CYC_MS(`PPFDM_T_ILIM_MS),
   parameter int UV_CYC = `PPFDM_CYC_MS(`PPFDM_T_UV_MS),
   parameter int FS_W = 8
) (
   input wire logic CLOCK_I,
   input wire logic RST_I,
   input wire logic CURRENT_LIMIT_MODE_ENABLE_I,
   input wire logic CABLE_POWER_ENABLE_I,
   input wire logic USB_RAIL_UV_I,
   input wire logic OVER_LIMIT_I,
   input wire logic OVER_OCP_I,
   input wire logic OVER_OVP_I,
   input wire logic UNDER_UV_I,
   input wire logic BELOW_2V0_I,
   input wire logic BELOW_2V85_I,
   input wire logic ABOVE_SAFE0_I,
   input wire logic CABLE_OC_LOW_I,
   input wire logic CABLE_OC_HIGH_I,
   input wire logic CABLE_FAST_UV_I,
   input wire logic OUTPUT_OFF_I,
   input wire logic SOFT_START_I,
   input wire logic TRANSITION_I,
   input wire logic DEFAULT_VOLTAGE_CMD_I,
   input wire logic CONVERTER_ENABLE_CMD_I,
   input wire logic CABLE_RETRY_DONE_I,
   input wire logic SUMMARY_MASK_I,
   input wire logic MODE_CHANGE_MASK_I,
   input wire logic [FS_W-1:0] FAULT_STATUS_MASK_I,
   input wire ppfdm_pkg::ppfdm_flags_t FLAG_CLEAR_I,
   input wire logic [FS_W-1:0] FAULT_STATUS_CLEAR_I,
   output ppfdm_pkg::ppfdm_flags_t FLAGS_O,
   output logic [FS_W-1:0] FAULT_STATUS_O,
   output logic VENDOR_ALERT_O,
   output logic ALERT_O,
   output logic CONVERTER_OFF_O,
   output logic DISCHARGE_O,
   output logic DATA_SWITCH_OPEN_O,
   output logic CC_SWITCH_OPEN_O,
   output logic CC_DISCHARGE_O,
   output logic CABLE_SWITCH_OPEN_O,
   output logic CABLE_RETRY_HOLD_O,
   output logic CABLE_STG_DETECT_O,
   output logic CHARGER_DETECT_RESET_O
);
   localparam int OCP0_CYC = `PPFDM_CYC_US(`PPFDM_T_OCP_OFF_US);
   localparam int OCP1_CYC = `PPFDM_CYC_US(`PPFDM_T_OCP_ON_US);
   localparam int OVP_CYC = `PPFDM_CYC_US(`PPFDM_T_OVP_ON_US);
   localparam int PB_CYC = `PPFDM_CYC_US(`PPFDM_T_PREBIAS_US);
   localparam int VCL_CYC = `PPFDM_CYC_US(`PPFDM_T_VCL_US);
   localparam int VCH_CYC = `PPFDM_CYC_US(`PPFDM_T_VCH_US);
   localparam int NP = 9;
   localparam int CW = 24;

   // Pin inputs pass three flops; a change counts when stages two and three
   // agree.
   logic [NP-1:0] pin_raw;
   logic [NP-1:0] s1_r;
   logic [NP-1:0] s2_r;
   logic [NP-1:0] s3_r;
   logic [NP-1:0] pin_r;
   assign pin_raw = {USB_RAIL_UV_I, OVER_LIMIT_I, OVER_OCP_I, OVER_OVP_I,
                     UNDER_UV_I, BELOW_2V0_I, BELOW_2V85_I, ABOVE_SAFE0_I,
                     CABLE_FAST_UV_I};
   logic [1:0] oc_raw;
   logic [1:0] oc1_r;
   logic [1:0] oc2_r;
   logic [1:0] oc3_r;
   logic [1:0] oc_r;
   assign oc_raw = {CABLE_OC_LOW_I, CABLE_OC_HIGH_I};

   always_ff @(posedge CLOCK_I)
   begin
      if (RST_I)
      begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
         pin_r <= '0;
         oc1_r <= '0;
         oc2_r <= '0;
         oc3_r <= '0;
         oc_r <= '0;
      end
      else
      begin
         s1_r <= pin_raw;
         s2_r <= s1_r;
         s3_r <= s2_r;
         pin_r <= (s2_r & s3_r) | (pin_r & (s2_r | s3_r));
         oc1_r <= oc_raw;
         oc2_r <= oc1_r;
         oc3_r <= oc2_r;
         oc_r <= (oc2_r & oc3_r) | (oc_r & (oc2_r | oc3_r));
      end
   end

   logic rail_uv, over_lim, over_ocp, over_ovp, under_uv;
   logic b2v0, b2v85, above0, fast_uv, oc_low, oc_high;
   assign {rail_uv, over_lim, over_ocp, over_ovp, under_uv, b2v0, b2v85,
           above0, fast_uv} = pin_r;
   assign {oc_low, oc_high} = oc_r;

   logic mode;
   assign mode = CURRENT_LIMIT_MODE_ENABLE_I;

   // Conditions and qualifying terms for each timed fault.
   logic ovp_blank;
   logic uv_blank;
   logic prebias_r;
   assign ovp_blank = OUTPUT_OFF_I | SOFT_START_I | (!mode & TRANSITION_I);
   assign uv_blank = OUTPUT_OFF_I | SOFT_START_I | (!mode & TRANSITION_I);

   localparam int ND = 7;
   logic [ND-1:0] cond;
   int lim [ND];
   assign cond[0] = over_lim & !mode;
   assign cond[1] = over_ocp;
   assign cond[2] = over_ovp & !ovp_blank;
   assign cond[3] = under_uv & !uv_blank & !(mode & FLAGS_O.in_current_regulation);
   assign cond[4] = prebias_r & above0;
   assign cond[5] = oc_low & CABLE_POWER_ENABLE_I;
   assign cond[6] = oc_high & CABLE_POWER_ENABLE_I;
   always_comb
   begin
      lim[0] = ILIM_CYC;
      lim[1] = mode ? OCP1_CYC : OCP0_CYC;
      lim[2] = mode ? OVP_CYC : 1;
      lim[3] = UV_CYC;
      lim[4] = PB_CYC;
      lim[5] = VCL_CYC;
      lim[6] = VCH_CYC;
   end

   // Each counter restarts whenever its condition lapses; fire is one pulse.
   logic [CW-1:0] cnt_r [ND];
   logic [ND-1:0] fire;
   genvar g;
   generate
      for (g = 0; g < ND; g++)
      begin : g_deb
         assign fire[g] = cond[g] && (cnt_r[g] == CW'(lim[g] - 1));
         always_ff @(posedge CLOCK_I)
         begin
            if (RST_I || !cond[g])
               cnt_r[g] <= '0;
            else if (cnt_r[g] < CW'(lim[g]))
               cnt_r[g] <= cnt_r[g] + CW'(1);
         end
      end
   endgenerate

   always_ff @(posedge CLOCK_I)
   begin
      if (RST_I)
         prebias_r <= 1'b0;
      else if (DEFAULT_VOLTAGE_CMD_I)
         prebias_r <= 1'b1;
      else if (!above0)
         prebias_r <= 1'b0;
   end

   // Immediate faults take the edge of their comparator.
   logic rail_uv_d_r, stg_d_r, fuv_d_r, lim_d_r;
   logic stg;
   assign stg = mode ? b2v85 : b2v0;
   always_ff @(posedge CLOCK_I)
   begin
      if (RST_I)
      begin
         rail_uv_d_r <= 1'b0;
         stg_d_r <= 1'b0;
         fuv_d_r <= 1'b0;
         lim_d_r <= 1'b0;
      end
      else
      begin
         rail_uv_d_r <= rail_uv;
         stg_d_r <= stg;
         fuv_d_r <= fast_uv & !CABLE_POWER_ENABLE_I;
         lim_d_r <= over_lim & mode;
      end
   end
   logic ev_rail, ev_stg, ev_fuv, ev_reg;
   assign ev_rail = rail_uv & !rail_uv_d_r;
   assign ev_stg = stg & !stg_d_r;
   assign ev_fuv = fast_uv & !CABLE_POWER_ENABLE_I & !fuv_d_r;
   assign ev_reg = over_lim & mode & !lim_d_r;

   // Cable overcurrent faults count toward the third one.
   logic [1:0] vc_cnt_r;
   logic vc_fire, vc_third;
   assign vc_fire = fire[5] | fire[6];
   assign vc_third = vc_fire && (vc_cnt_r == `PPFDM_THIRD_FAULT - 2'h1);
   always_ff @(posedge CLOCK_I)
   begin
      if (RST_I || !CABLE_POWER_ENABLE_I)
         vc_cnt_r <= '0;
      else if (vc_third)
         vc_cnt_r <= '0;
      else if (vc_fire)
         vc_cnt_r <= vc_cnt_r + 2'h1;
   end

   logic class_a, class_b, class_c;
   assign class_a = fire[0] | fire[1] | fire[2] | ev_stg;
   assign class_b = vc_fire | ev_fuv;
   assign class_c = ev_rail | fire[3] | fire[4];

   // Flags: set wins over clear, held until cleared.
   ppfdm_pkg::ppfdm_flags_t set_f;
   always_comb
   begin
      set_f = '0;
      set_f.usb_rail_undervolt = ev_rail;
      set_f.limit_exceeded = fire[0];
      set_f.in_current_regulation = ev_reg;
      set_f.mode_change = ev_reg;
      set_f.bus_overcurrent = fire[1];
      set_f.bus_overvoltage = fire[2];
      set_f.bus_undervoltage = fire[3];
      set_f.output_short_ground = ev_stg;
      set_f.host_error = fire[4];
      set_f.cable_power_low_overcurrent = vc_third & fire[5];
      set_f.cable_power_overcurrent = vc_third;
      set_f.cable_power_input_undervolt = ev_fuv;
      set_f.protection_summary = ev_rail | fire[0] | fire[3] | ev_stg |
                                 (vc_third & fire[5]);
   end
   logic [FS_W-1:0] fs_set;
   always_comb
   begin
      fs_set = '0;
      fs_set[`PPFDM_FS_OCP] = fire[1];
      fs_set[`PPFDM_FS_OVP] = fire[2];
      fs_set[`PPFDM_FS_HOST] = fire[4];
      fs_set[`PPFDM_FS_VCONN] = vc_third;
   end
   always_ff @(posedge CLOCK_I)
   begin
      if (RST_I)
      begin
         FLAGS_O <= '0;
         FAULT_STATUS_O <= '0;
      end
      else
      begin
         FLAGS_O <= set_f | (FLAGS_O & ~FLAG_CLEAR_I);
         FAULT_STATUS_O <= fs_set | (FAULT_STATUS_O & ~FAULT_STATUS_CLEAR_I);
      end
   end

   // Alert gating and fault actions.
   logic alert_ev;
   assign alert_ev = class_a | class_c | vc_third | ev_fuv;
   always_ff @(posedge CLOCK_I)
   begin
      if (RST_I)
      begin
         VENDOR_ALERT_O <= 1'b0;
         ALERT_O <= 1'b0;
      end
      else
      begin
         VENDOR_ALERT_O <= SUMMARY_MASK_I &
            (FLAGS_O.protection_summary | FLAGS_O.usb_rail_undervolt |
             FLAGS_O.cable_power_input_undervolt |
             FLAGS_O.in_current_regulation);
         ALERT_O <= (SUMMARY_MASK_I & FLAGS_O.protection_summary) |
            (MODE_CHANGE_MASK_I & FLAGS_O.mode_change) |
            (|(FAULT_STATUS_O & FAULT_STATUS_MASK_I)) |
            (SUMMARY_MASK_I & alert_ev);
      end
   end

   always_ff @(posedge CLOCK_I)
   begin
      if (RST_I)
      begin
         CONVERTER_OFF_O <= 1'b0;
         DISCHARGE_O <= 1'b0;
         DATA_SWITCH_OPEN_O <= 1'b0;
         CC_SWITCH_OPEN_O <= 1'b0;
         CC_DISCHARGE_O <= 1'b0;
         CHARGER_DETECT_RESET_O <= 1'b0;
      end
      else
      begin
         CHARGER_DETECT_RESET_O <= class_a;
         if (class_a)
         begin
            CONVERTER_OFF_O <= 1'b1;
            DISCHARGE_O <= 1'b1;
            DATA_SWITCH_OPEN_O <= 1'b1;
            CC_SWITCH_OPEN_O <= 1'b1;
            CC_DISCHARGE_O <= 1'b1;
         end
         else if (CONVERTER_ENABLE_CMD_I)
         begin
            CONVERTER_OFF_O <= 1'b0;
            DISCHARGE_O <= 1'b0;
            DATA_SWITCH_OPEN_O <= 1'b0;
            CC_SWITCH_OPEN_O <= 1'b0;
            CC_DISCHARGE_O <= 1'b0;
         end
      end
   end

   always_ff @(posedge CLOCK_I)
   begin
      if (RST_I)
      begin
         CABLE_SWITCH_OPEN_O <= 1'b0;
         CABLE_RETRY_HOLD_O <= 1'b0;
         CABLE_STG_DETECT_O <= 1'b0;
      end
      else
      begin
         CABLE_STG_DETECT_O <= class_b;
         if (class_a | class_b)
            CABLE_SWITCH_OPEN_O <= 1'b1;
         else if (CABLE_RETRY_DONE_I)
            CABLE_SWITCH_OPEN_O <= 1'b0;
         if (class_a | vc_third)
            CABLE_RETRY_HOLD_O <= 1'b1;
         else if (CABLE_RETRY_DONE_I)
            CABLE_RETRY_HOLD_O <= 1'b0;
      end
   end
endmodule

// *** verif/ppfdm_host_model.sv ***
// Host-side model that issues flag clears and converter re-enables.
`timescale 1ns/1ps
module ppfdm_host_model (
   input wire logic CLOCK_I,
   input wire logic CLEAR_REQ_I,
   input wire logic ENABLE_REQ_I,
   output ppfdm_pkg::ppfdm_flags_t FLAG_CLEAR_O,
   output logic [7:0] FS_CLEAR_O,
   output logic ENABLE_CMD_O
);
   initial {FLAG_CLEAR_O, FS_CLEAR_O, ENABLE_CMD_O} = '0;
   // Each request is passed on a cycle later: clear as write-one-to-clear on all flags, enable as the enable command.
   always @(posedge CLOCK_I)
   begin
      FLAG_CLEAR_O <= {13{CLEAR_REQ_I}};
      FS_CLEAR_O <= {8{CLEAR_REQ_I}};
      ENABLE_CMD_O <= ENABLE_REQ_I;
   end
endmodule

// *** verif/ppfdm_monitor_sva.sv ***
// Concurrent checks on the port power fault monitor ports.
`timescale 1ns/1ps
module ppfdm_monitor_sva #(
   parameter int ILIM_CYC = 100,
   parameter int UV_CYC = 100,
   parameter int FS_W = 8
) (
   input wire logic CLOCK_I,
   input wire logic RST_I,
   input wire logic CURRENT_LIMIT_MODE_ENABLE_I,
   input wire logic OUTPUT_OFF_I,
   input wire logic CONVERTER_ENABLE_CMD_I,
   input wire logic SUMMARY_MASK_I,
   input wire ppfdm_pkg::ppfdm_flags_t FLAG_CLEAR_I,
   input wire ppfdm_pkg::ppfdm_flags_t FLAGS_O,
   input wire logic [FS_W-1:0] FAULT_STATUS_O,
   input wire logic VENDOR_ALERT_O,
   input wire logic CONVERTER_OFF_O,
   input wire logic DISCHARGE_O,
   input wire logic CC_SWITCH_OPEN_O,
   input wire logic CABLE_SWITCH_OPEN_O,
   input wire logic CABLE_STG_DETECT_O,
   input wire logic CHARGER_DETECT_RESET_O
);
   default clocking cb @(posedge CLOCK_I);
   endclocking
   default disable iff (RST_I);
   property p_sticky;
      1 |=> ($past(FLAGS_O) & ~$past(FLAG_CLEAR_I) & ~FLAGS_O) == '0;
   endproperty
   a_sticky: assert property (p_sticky) else $error("flag lost");
   property p_class_a;
      $rose(CONVERTER_OFF_O) |->
         DISCHARGE_O && CC_SWITCH_OPEN_O && CHARGER_DETECT_RESET_O;
   endproperty
   a_class_a: assert property (p_class_a) else $error("class A");
   property p_hold;
      CONVERTER_OFF_O && !CONVERTER_ENABLE_CMD_I |=> CONVERTER_OFF_O;
   endproperty
   a_hold: assert property (p_hold) else $error("off dropped");
   property p_vmask;
      !SUMMARY_MASK_I |=> !VENDOR_ALERT_O;
   endproperty
   a_vmask: assert property (p_vmask) else $error("vendor alert");
   property p_ocp;
      $rose(FLAGS_O.bus_overcurrent) |-> FAULT_STATUS_O[0];
   endproperty
   a_ocp: assert property (p_ocp) else $error("ocp status");
   property p_ovp_blank;
      OUTPUT_OFF_I [*3] |-> !$rose(FLAGS_O.bus_overvoltage);
   endproperty
   a_ovp_blank: assert property (p_ovp_blank) else $error("ovp");
   property p_limit;
      CURRENT_LIMIT_MODE_ENABLE_I [*3] |-> !$rose(FLAGS_O.limit_exceeded);
   endproperty
   a_limit: assert property (p_limit) else $error("limit");
   property p_rail;
      $rose(FLAGS_O.usb_rail_undervolt) |-> FLAGS_O.protection_summary;
   endproperty
   a_rail: assert property (p_rail) else $error("rail summary");
   property p_stg_detect;
      CABLE_STG_DETECT_O |-> CABLE_SWITCH_OPEN_O;
   endproperty
   a_stg_detect: assert property (p_stg_detect) else $error("stg detect");
endmodule
bind ppfdm_monitor ppfdm_monitor_sva #(.ILIM_CYC(ILIM_CYC),
   .UV_CYC(UV_CYC), .FS_W(FS_W)) ppfdm_monitor_sva_i (.CLOCK_I(CLOCK_I),
   .RST_I(RST_I), .CURRENT_LIMIT_MODE_ENABLE_I(CURRENT_LIMIT_MODE_ENABLE_I),
   .OUTPUT_OFF_I(OUTPUT_OFF_I), .SUMMARY_MASK_I(SUMMARY_MASK_I),
   .CONVERTER_ENABLE_CMD_I(CONVERTER_ENABLE_CMD_I),
   .FLAG_CLEAR_I(FLAG_CLEAR_I), .FLAGS_O(FLAGS_O),
   .FAULT_STATUS_O(FAULT_STATUS_O), .VENDOR_ALERT_O(VENDOR_ALERT_O),
   .CONVERTER_OFF_O(CONVERTER_OFF_O), .DISCHARGE_O(DISCHARGE_O),
   .CC_SWITCH_OPEN_O(CC_SWITCH_OPEN_O),
   .CABLE_SWITCH_OPEN_O(CABLE_SWITCH_OPEN_O),
   .CABLE_STG_DETECT_O(CABLE_STG_DETECT_O),
   .CHARGER_DETECT_RESET_O(CHARGER_DETECT_RESET_O));

// *** verif/ppfdm_monitor_test.sv ***
// Self-checking bench for the port power fault monitor.
`timescale 1ns/1ps
module ppfdm_monitor_test;
   logic CLOCK_I = 0, RST_I = 1, clm = 0, cpe = 1, sm = 0, dv = 0, rd = 0;
   logic clr = 0, ren = 0, va, co, ds, dso, cso, ccd, cbo, crh, en, al;
   logic [10:0] cmp = '0;
   logic [2:0] blk = '0;
   logic [7:0] fsm = 8'hff, fsc, fs;
   int err_total = 0, n_tests = 0, seed = 32'h6727;
   ppfdm_pkg::ppfdm_flags_t fc, f;
   ppfdm_host_model ppfdm_host_model_i (.CLOCK_I(CLOCK_I), .CLEAR_REQ_I(clr),
      .ENABLE_REQ_I(ren), .FLAG_CLEAR_O(fc), .FS_CLEAR_O(fsc),
      .ENABLE_CMD_O(en));
   ppfdm_monitor #(.ILIM_CYC(100), .UV_CYC(100)) ppfdm_monitor_i (
      .CLOCK_I(CLOCK_I), .RST_I(RST_I), .CURRENT_LIMIT_MODE_ENABLE_I(clm),
      .CABLE_POWER_ENABLE_I(cpe), .USB_RAIL_UV_I(cmp[0]),
      .OVER_LIMIT_I(cmp[1]), .OVER_OCP_I(cmp[2]), .OVER_OVP_I(cmp[3]),
      .UNDER_UV_I(cmp[4]), .BELOW_2V0_I(cmp[5]), .BELOW_2V85_I(cmp[6]),
      .ABOVE_SAFE0_I(cmp[7]), .CABLE_OC_LOW_I(cmp[8]),
      .CABLE_OC_HIGH_I(cmp[9]), .CABLE_FAST_UV_I(cmp[10]),
      .OUTPUT_OFF_I(blk[2]), .SOFT_START_I(blk[1]), .TRANSITION_I(blk[0]),
      .DEFAULT_VOLTAGE_CMD_I(dv), .CONVERTER_ENABLE_CMD_I(en),
      .CABLE_RETRY_DONE_I(rd), .SUMMARY_MASK_I(sm), .MODE_CHANGE_MASK_I(sm),
      .FAULT_STATUS_MASK_I(fsm), .FLAG_CLEAR_I(fc),
      .FAULT_STATUS_CLEAR_I(fsc), .FLAGS_O(f), .FAULT_STATUS_O(fs),
      .VENDOR_ALERT_O(va), .ALERT_O(al), .CONVERTER_OFF_O(co),
      .DISCHARGE_O(ds), .DATA_SWITCH_OPEN_O(dso), .CC_SWITCH_OPEN_O(cso),
      .CC_DISCHARGE_O(ccd), .CABLE_SWITCH_OPEN_O(cbo),
      .CABLE_RETRY_HOLD_O(crh), .CABLE_STG_DETECT_O(),
      .CHARGER_DETECT_RESET_O());
   initial forever #2 CLOCK_I = ~CLOCK_I;
   // The sequence needs about 32000 cycles; allow well over that.
   initial
   begin
      repeat (60000) @(posedge CLOCK_I);
      err_total++;
      summarize();
   end
   // Debounce time in microseconds converted to clock cycles.
   function automatic int deb(input int t_us);
      return t_us * 250;
   endfunction
   task automatic chk(input logic g, input logic e);
      n_tests++;
      if (g !== e)
      begin
         err_total++;
         $display("Error at %0t: got %b, expected %b", $time, g, e);
      end
   endtask
   // Raise one comparator for n cycles, then let the synchronisers settle.
   task automatic hold(input int i, input int n);
      @(posedge CLOCK_I) cmp[i] <= 1'b1;
      repeat (n) @(posedge CLOCK_I);
      cmp[i] <= 1'b0;
      repeat (8) @(posedge CLOCK_I);
      #1;
   endtask
   task automatic host(input logic e);
      @(posedge CLOCK_I) {clr, ren} <= {1'b1, e};
      @(posedge CLOCK_I) {clr, ren} <= 2'h0;
      repeat (3) @(posedge CLOCK_I);
      #1;
   endtask
   task automatic retry();
      @(posedge CLOCK_I) rd <= 1'b1;
      @(posedge CLOCK_I) rd <= 1'b0;
   endtask
   task automatic blanked(input int ci, input int fi, input int n);
      for (int b = 0; b < 3; b++)
      begin
         @(posedge CLOCK_I) blk <= 3'h1 << b;
         hold(ci, n);
         chk(f[fi], 1'b0);
      end
      @(posedge CLOCK_I) blk <= 3'h0;
   endtask
   task automatic fin(input string s);
      $display("Test %s done at %0t", s, $time);
   endtask
   task summarize();
      $display("Compares %0d, mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial
   begin
      repeat (20) @(posedge CLOCK_I);
      RST_I <= 1'b0;
      hold(0, 2 + ($random(seed) & 7));
      chk(f.usb_rail_undervolt & f.protection_summary, 1'b1);
      chk(va, 1'b0);
      hold(1, 0);
      @(posedge CLOCK_I) sm <= 1'b1;
      hold(1, 0);
      chk(va, 1'b1);
      host(1'b0);
      chk(f.usb_rail_undervolt, 1'b0);
      fin("rail");
      hold(2, deb(50) - 300 - ($random(seed) & 255));
      chk(f.bus_overcurrent, 1'b0);
      hold(2, deb(50) + 20);
      chk(f.bus_overcurrent & fs[0], 1'b1);
      chk(co & ds & dso & cso & ccd & cbo, 1'b1);
      chk(al, 1'b1);
      host(1'b0);
      chk(co, 1'b1);
      host(1'b1);
      chk(co | ds | dso | cso | ccd, 1'b0);
      hold(1, 130);
      chk(f.limit_exceeded & co, 1'b1);
      @(posedge CLOCK_I) clm <= 1'b1;
      host(1'b1);
      hold(1, 130);
      chk(f.in_current_regulation & f.mode_change, 1'b1);
      chk(f.limit_exceeded | co, 1'b0);
      hold(4, 130);
      chk(f.bus_undervoltage, 1'b0);
      fin("current");
      @(posedge CLOCK_I) clm <= 1'b0;
      blanked(4, 6, 130);
      hold(4, 130);
      chk(f.bus_undervoltage & f.protection_summary, 1'b1);
      blanked(3, 7, 6);
      hold(3, 6);
      chk(f.bus_overvoltage & fs[1], 1'b1);
      for (int m = 0; m < 2; m++)
      begin
         @(posedge CLOCK_I) clm <= m[0];
         host(1'b1);
         hold(5 + m, 6);
         chk(f.output_short_ground & co, 1'b1);
      end
      fin("voltage");
      // The output must already read above safe zero through the
      // synchroniser when the command arrives, or the latch drops at once.
      @(posedge CLOCK_I) cmp[7] <= 1'b1;
      repeat (6) @(posedge CLOCK_I);
      dv <= 1'b1;
      @(posedge CLOCK_I) dv <= 1'b0;
      repeat (deb(10) - 100) @(posedge CLOCK_I);
      #1;
      chk(f.host_error, 1'b0);
      hold(7, 120);
      chk(f.host_error & fs[2], 1'b1);
      for (int k = 1; k < 4; k++)
      begin
         retry();
         hold(9, deb(5) + 20);
         chk(f.cable_power_overcurrent, k == 3);
         chk(crh, k == 3);
      end
      retry();
      @(posedge CLOCK_I) cpe <= 1'b0;
      hold(10, 6);
      chk(f.cable_power_input_undervolt & cbo, 1'b1);
      fin("cable");
      summarize();
   end
endmodule
